// ==== hw/dego_regs.vh ====
`ifndef DEGO_REGS_VH
`define DEGO_REGS_VH

// ****************************************
// register map
// ****************************************
`define DEGO_CTRL_OFF        8'h00
`define DEGO_STAT_OFF        8'h04
`define DEGO_CTRL_RST        9'h000

// ****************************************
// control fields
// ****************************************
`define DEGO_C_IN_REG        0
`define DEGO_C_OUT_REG       1
`define DEGO_C_OE_REG        2
`define DEGO_C_IN_FALL       3
`define DEGO_C_OUT_FALL      4
`define DEGO_C_OE_FALL       5
`define DEGO_C_DUAL          6
`define DEGO_C_RESYNC        7
`define DEGO_C_INVERT        8
`define DEGO_CTRL_W          9

// ****************************************
// status fields
// ****************************************
`define DEGO_S_LEVEL_LO      0
`define DEGO_S_FULL          3
`define DEGO_S_EMPTY         4
`define DEGO_S_PAD           5
`define DEGO_S_DUAL_ON       6
`define DEGO_S_OVERRUN       7

// ****************************************
// capture buffer
// ****************************************
`define DEGO_FIFO_W          2
`define DEGO_FIFO_D          4
`define DEGO_FIFO_AW         2

`endif

// ==== hw/dego_top.v ====
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dego_regs.vh"

// ****************************************
// capture fifo
// ****************************************
module dego_fifo #(
    parameter W  = 2,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire [W-1:0]  in_data_i,
    input  wire          in_valid_i,
    output wire          in_ready_o,
    output wire [W-1:0]  out_data_o,
    output wire          out_valid_o,
    input  wire          out_ready_i,
    output wire [AW:0]   level_o
);
    reg  [W-1:0]  mem_r [0:D-1];
    reg  [AW-1:0] wr_r;
    reg  [AW-1:0] rd_r;
    reg  [AW:0]   cnt_r;
    wire          push;
    wire          pop;
    integer       i;

    assign in_ready_o  = (cnt_r != D[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o  = mem_r[rd_r];
    assign level_o     = cnt_r;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            for (i = 0; i < D; i = i + 1) begin
                mem_r[i] <= {W{1'b0}};
            end
        end else begin
            if (push) begin
                mem_r[wr_r] <= in_data_i;
                wr_r        <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ****************************************
// gpio io logic
// ****************************************
module dego_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [31:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg         wb_ack_o,
    input  wire        pad_is_diff_pair_i,
    input  wire        capture_side_clock_i,
    input  wire        drive_side_clock_i,
    input  wire        core_to_pad_rise_i,
    input  wire        core_to_pad_fall_i,
    input  wire        drive_gate_i,
    output reg         pad_to_core_rise_o,
    output reg         pad_to_core_fall_o,
    output reg         pad_to_core_valid_o,
    input  wire        pad_to_core_ready_i,
    output reg         capture_ready_o,
    output reg         bypass_path_o,
    input  wire        pad_i,
    output reg         pad_o,
    output reg         pad_oe_o
);
    reg  [`DEGO_CTRL_W-1:0] ctrl_r;
    reg                     overrun_r;
    reg  [1:0]              pad_s_r;
    reg  [2:0]              cclk_s_r;
    reg  [2:0]              dclk_s_r;
    reg                     cap_rise_r;
    reg                     cap_fall_r;
    reg                     drv_rise_r;
    reg                     drv_fall_r;
    reg                     gate_r;
    reg                     data_nxt;
    reg                     gate_nxt;
    reg                     push_nxt;
    reg  [1:0]              word_nxt;
    wire                    in_reg;
    wire                    out_reg;
    wire                    oe_reg;
    wire                    dual_on;
    wire                    resync;
    wire                    pad_s;
    wire                    c_rise;
    wire                    c_fall;
    wire                    d_rise;
    wire                    d_fall;
    wire                    c_sel;
    wire                    d_sel;
    wire                    g_sel;
    wire                    f_ready;
    wire [1:0]              f_data;
    wire                    f_valid;
    wire                    f_pop;
    wire [`DEGO_FIFO_AW:0]  f_level;
    wire                    wb_req;
    wire [7:0]              wb_off;
    wire                    overrun_set;

    assign in_reg  = ctrl_r[`DEGO_C_IN_REG];
    assign out_reg = ctrl_r[`DEGO_C_OUT_REG];
    assign oe_reg  = ctrl_r[`DEGO_C_OE_REG];
    assign dual_on = ctrl_r[`DEGO_C_DUAL] & ~pad_is_diff_pair_i;
    assign resync  = ctrl_r[`DEGO_C_RESYNC];
    assign pad_s   = pad_s_r[1];
    // edges read the second stage and its delayed copy only
    assign c_rise  = cclk_s_r[1] & ~cclk_s_r[2];
    assign c_fall  = ~cclk_s_r[1] & cclk_s_r[2];
    assign d_rise  = dclk_s_r[1] & ~dclk_s_r[2];
    assign d_fall  = ~dclk_s_r[1] & dclk_s_r[2];
    assign c_sel   = ctrl_r[`DEGO_C_IN_FALL] ? c_fall : c_rise;
    assign d_sel   = ctrl_r[`DEGO_C_OUT_FALL] ? d_fall : d_rise;
    assign g_sel   = ctrl_r[`DEGO_C_OE_FALL] ? d_fall : d_rise;
    assign f_pop   = ~pad_to_core_valid_o | pad_to_core_ready_i;
    assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_off  = wb_adr_i[7:0];
    assign overrun_set = push_nxt & ~f_ready;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            pad_s_r  <= 2'b00;
            cclk_s_r <= 3'b000;
            dclk_s_r <= 3'b000;
        end else begin
            pad_s_r  <= {pad_s_r[0], pad_i};
            cclk_s_r <= {cclk_s_r[1:0], capture_side_clock_i};
            dclk_s_r <= {dclk_s_r[1:0], drive_side_clock_i};
        end
    end

    // ****************************************
    // capture side
    // ****************************************
    always @* begin
        push_nxt = 1'b0;
        word_nxt = 2'b00;
        if (in_reg) begin
            if (dual_on) begin
                if (resync) begin
                    push_nxt = c_rise;
                    word_nxt = {cap_fall_r, pad_s};
                end else begin
                    push_nxt = c_fall;
                    word_nxt = {pad_s, cap_rise_r};
                end
            end else begin
                push_nxt = c_sel;
                word_nxt = {1'b0, pad_s};
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cap_rise_r <= 1'b0;
            cap_fall_r <= 1'b0;
        end else begin
            if (c_rise) begin
                cap_rise_r <= pad_s;
            end
            if (c_fall) begin
                cap_fall_r <= pad_s;
            end
        end
    end

    dego_fifo #(
        .W  (`DEGO_FIFO_W),
        .D  (`DEGO_FIFO_D),
        .AW (`DEGO_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (word_nxt),
        .in_valid_i  (push_nxt),
        .in_ready_o  (f_ready),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop),
        .level_o     (f_level)
    );

    always @(posedge clk_i) begin
        if (rst_i) begin
            pad_to_core_rise_o  <= 1'b0;
            pad_to_core_fall_o  <= 1'b0;
            pad_to_core_valid_o <= 1'b0;
            capture_ready_o     <= 1'b0;
            bypass_path_o       <= 1'b0;
        end else begin
            capture_ready_o <= f_ready;
            bypass_path_o   <= (~in_reg & ~out_reg & ~oe_reg) & pad_s;
            if (~in_reg) begin
                pad_to_core_rise_o  <= pad_s;
                pad_to_core_fall_o  <= 1'b0;
                pad_to_core_valid_o <= 1'b1;
            end else if (f_pop) begin
                pad_to_core_rise_o  <= f_data[0];
                pad_to_core_fall_o  <= f_data[1];
                pad_to_core_valid_o <= f_valid;
            end
        end
    end

    // ****************************************
    // drive side
    // ****************************************
    always @* begin
        data_nxt = pad_o;
        if (~out_reg) begin
            data_nxt = core_to_pad_rise_i;
        end else if (dual_on) begin
            if (d_rise) begin
                data_nxt = drv_rise_r ^ ctrl_r[`DEGO_C_INVERT];
            end else if (d_fall) begin
                data_nxt = drv_fall_r ^ ctrl_r[`DEGO_C_INVERT];
            end
        end else if (d_sel) begin
            data_nxt = core_to_pad_rise_i ^ ctrl_r[`DEGO_C_INVERT];
        end
        gate_nxt = oe_reg ? gate_r : drive_gate_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            drv_rise_r <= 1'b0;
            drv_fall_r <= 1'b0;
            gate_r     <= 1'b0;
            pad_o      <= 1'b0;
            pad_oe_o   <= 1'b0;
        end else begin
            // launch registers load one edge ahead of the pad, except the fall bit with resync set: it loads at the fall a whole period ahead
            if (d_fall | (d_rise & ~dual_on)) begin
                drv_rise_r <= core_to_pad_rise_i;
            end
            if (resync ? d_fall : d_rise) begin
                drv_fall_r <= core_to_pad_fall_i;
            end
            if (resync & d_fall) begin
                drv_fall_r <= core_to_pad_fall_i;
            end
            if (g_sel) begin
                gate_r <= drive_gate_i;
            end
            pad_o    <= data_nxt;
            pad_oe_o <= gate_nxt;
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r    <= `DEGO_CTRL_RST;
            overrun_r <= 1'b0;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req & wb_we_i & (wb_off == `DEGO_CTRL_OFF)) begin
                if (wb_sel_i[0]) begin
                    ctrl_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl_r[8] <= wb_dat_i[8];
                end
            end
            // a new overrun wins over a clear in the same cycle
            if (overrun_set) begin
                overrun_r <= 1'b1;
            end else if (wb_req & wb_we_i & wb_sel_i[0] & (wb_off == `DEGO_STAT_OFF)
                         & wb_dat_i[`DEGO_S_OVERRUN]) begin
                overrun_r <= 1'b0;
            end
            if (wb_req & ~wb_we_i) begin
                if (wb_off == `DEGO_CTRL_OFF) begin
                    wb_dat_o <= {23'h00_0000, ctrl_r};
                end else if (wb_off == `DEGO_STAT_OFF) begin
                    wb_dat_o <= {24'h00_0000, overrun_r, dual_on, pad_s,
                                 ~f_valid, ~f_ready, f_level};
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== sim/dego_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bus and stream checks
// ****************************************
module dego_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        pad_to_core_rise_o,
    input wire logic        pad_to_core_fall_o,
    input wire logic        pad_to_core_valid_o,
    input wire logic        pad_to_core_ready_i,
    input wire logic        bypass_path_o,
    input wire logic        pad_o,
    input wire logic        pad_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_valid_stays: assert property (pad_to_core_valid_o && !pad_to_core_ready_i |=>
        pad_to_core_valid_o) else $error("valid dropped without ready");
    a_word_stable: assert property (pad_to_core_valid_o && !pad_to_core_ready_i |=>
        $stable({pad_to_core_rise_o, pad_to_core_fall_o}))
        else $error("word changed while stalled");
    a_reset_bus_quiet: assert property ($past(rst_i) |-> !wb_ack_o && wb_dat_o == 0)
        else $error("bus active after reset");
    a_reset_pad_quiet: assert property ($past(rst_i) |-> !pad_oe_o && !pad_o &&
        !pad_to_core_valid_o && !bypass_path_o)
        else $error("pad side active after reset");
endmodule

bind dego_top dego_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .pad_to_core_rise_o, .pad_to_core_fall_o, .pad_to_core_valid_o,
    .pad_to_core_ready_i, .bypass_path_o, .pad_o, .pad_oe_o);
`default_nettype wire

// ==== sim/dego_far.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// core clocks and pad far side
// ****************************************
module dego_far (
    input wire logic clk_i,
    input wire logic pad_o,
    input wire logic pad_oe_o,
    output var logic pad_i,
    output var logic cclk_o,
    output var logic dclk_o
);
    logic drv;
    // pad resolves to the design when it drives, else to the far driver
    assign pad_i = pad_oe_o ? pad_o : drv;
    initial begin
        drv = 1'b1;
        cclk_o = 1'b0;
        dclk_o = 1'b0;
    end
    // one capture clock period: a before the rise, b before the fall
    task send(input logic a, input logic b);
        @(posedge clk_i) drv <= a;
        repeat (4) @(posedge clk_i);
        cclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        drv <= b;
        repeat (4) @(posedge clk_i);
        cclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task dedge(input logic lv);
        dclk_o <= lv;
        repeat (6) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ==== sim/dego_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dego_top_tb;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i;
    logic        diff, crise, cfall, gate, ready, p_rise, p_fall, p_valid;
    logic        cap_rdy, byp, pad_i, pad_o, pad_oe, cclk, dclk;
    int          failures = 0;
    int          total_checks = 0;

    dego_top dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pad_is_diff_pair_i(diff),
        .capture_side_clock_i(cclk), .drive_side_clock_i(dclk),
        .core_to_pad_rise_i(crise), .core_to_pad_fall_i(cfall),
        .drive_gate_i(gate), .pad_to_core_rise_o(p_rise),
        .pad_to_core_fall_o(p_fall), .pad_to_core_valid_o(p_valid),
        .pad_to_core_ready_i(ready), .capture_ready_o(cap_rdy),
        .bypass_path_o(byp), .pad_i, .pad_o, .pad_oe_o(pad_oe));
    dego_far far_u (.clk_i, .pad_o, .pad_oe_o(pad_oe), .pad_i, .cclk_o(cclk),
        .dclk_o(dclk));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        failures++;
        conclude();
    end

    task conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {24'h00_0000, a};
        wb_dat_i <= d;
        // only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, e, rd & m);
    endtask
    task get(input logic r, input logic f);
        int n;
        n = 0;
        while (p_valid !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk("word", {29'h0000_0000, 1'b1, r, f}, {29'h0000_0000, p_valid, p_rise, p_fall});
        ready <= 1'b1;
        @(posedge clk_i);
        ready <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task setup(input logic [31:0] c);
        xfer(8'h00, 1'b1, c);
        repeat (12) begin
            ready <= 1'b1;
            @(posedge clk_i);
        end
        ready <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        rst_i = 1'b1;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        diff = 1'b0;
        crise = 1'b0;
        cfall = 1'b0;
        gate = 1'b0;
        // unregistered input follows the pad, so the core always accepts there
        ready = 1'b1;
        wb_adr_i = 32'h0000_0000;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'hf;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("ctrl", 8'h00, 32'hffff_ffff, 32'h0000_0000);
        wb_sel_i <= 4'h2;
        xfer(8'h00, 1'b1, 32'h0000_01ff);
        wb_sel_i <= 4'hf;
        rdc("ctrl_lane1", 8'h00, 32'hffff_ffff, 32'h0000_0100);
        xfer(8'h00, 1'b1, 32'h0000_0000);
        xfer(8'h08, 1'b1, 32'hffff_ffff);
        rdc("unmapped", 8'h08, 32'hffff_ffff, 32'h0000_0000);
        $display("registers done");
        gate <= 1'b1;
        crise <= 1'b1;
        far_u.drv <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("pad", 32'h3, {pad_oe, pad_o});
        chk("bypass", 32'h1, byp);
        chk("pass", 32'h1, p_rise);
        gate <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("pad_oe", 32'h0, pad_oe);
        chk("pass", 32'h0, p_rise);
        setup(32'h0000_0001);
        far_u.drv <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("bypass", 32'h0, byp);
        $display("pass-through done");
        xfer(8'h04, 1'b1, 32'h0000_0080);
        foreach (rd[i]) if (i < 6) far_u.send(i % 3 != 1, 1'b0);
        rdc("stat", 8'h04, 32'h0000_009f, 32'h0000_008c);
        chk("cap_rdy", 32'h0, cap_rdy);
        get(1, 0);
        get(0, 0);
        get(1, 0);
        get(1, 0);
        get(0, 0);
        rdc("stat", 8'h04, 32'h0000_009f, 32'h0000_0090);
        xfer(8'h04, 1'b1, 32'h0000_0080);
        rdc("stat", 8'h04, 32'h0000_0080, 32'h0000_0000);
        $display("single capture done");
        setup(32'h0000_0041);
        far_u.send(1, 0);
        get(1, 0);
        far_u.send(0, 1);
        get(0, 1);
        diff <= 1'b1;
        rdc("dual_on", 8'h04, 32'h0000_0040, 32'h0000_0000);
        diff <= 1'b0;
        rdc("dual_on", 8'h04, 32'h0000_0040, 32'h0000_0040);
        setup(32'h0000_00c1);
        far_u.send(1, 0);
        setup(32'h0000_00c1);
        far_u.send(0, 1);
        get(0, 0);
        far_u.send(1, 0);
        get(1, 1);
        setup(32'h0000_0009);
        far_u.send(0, 1);
        get(1, 0);
        ready <= 1'b1;
        $display("dual capture done");
        xfer(8'h00, 1'b1, 32'h0000_0042);
        gate <= 1'b1;
        crise <= 1'b1;
        // rise bit is taken at the fall before, fall bit at the rise
        far_u.dedge(1);
        far_u.dedge(0);
        far_u.dedge(1);
        chk("pad", 32'h1, pad_o);
        crise <= 1'b0;
        cfall <= 1'b1;
        far_u.dedge(0);
        chk("pad", 32'h0, pad_o);
        far_u.dedge(1);
        chk("pad", 32'h0, pad_o);
        far_u.dedge(0);
        chk("pad", 32'h1, pad_o);
        xfer(8'h00, 1'b1, 32'h0000_0102);
        crise <= 1'b1;
        far_u.dedge(1);
        chk("pad", 32'h0, pad_o);
        far_u.dedge(0);
        xfer(8'h00, 1'b1, 32'h0000_0012);
        far_u.dedge(1);
        chk("pad", 32'h0, pad_o);
        far_u.dedge(0);
        chk("pad", 32'h1, pad_o);
        xfer(8'h00, 1'b1, 32'h0000_0026);
        gate <= 1'b0;
        far_u.dedge(1);
        chk("pad_oe", 32'h1, pad_oe);
        far_u.dedge(0);
        chk("pad_oe", 32'h0, pad_oe);
        $display("drive done");
        conclude();
    end
endmodule
`default_nettype wire
